// File: hw/core_ctrl_pkg.sv
/*
 shared constants, register map, state codes and carrier types.
 assumes 32-bit AXI4-Lite with 8-bit byte addresses.
*/
package core_ctrl_pkg;
	localparam int unsigned AXI_AW = 8;
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_VBASE = 8'h04;
	localparam logic [7:0] OFF_CACHE = 8'h08;
	localparam logic [7:0] OFF_NC0 = 8'h0c;
	localparam logic [7:0] OFF_NC1 = 8'h10;
	localparam logic [7:0] OFF_STATE = 8'h14;
	localparam logic [1:0] GREG_PAGE = 2'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int unsigned SR_S_BIT = 13;
	localparam int unsigned SR_T_BIT = 15;
	localparam int unsigned SR_MASK_LSB = 8;
	localparam logic [15:0] SR_RESET = 16'h2700;
	localparam logic [31:0] VBASE_KEEP = 32'hfff0_0000;
	localparam int unsigned CACHE_EN_BIT = 31;
	localparam int unsigned NC_EN_BIT = 15;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [2:0] IRQ_NMI_LEVEL = 3'h7;
	localparam logic [7:0] VEC_ACCESS = 8'h02;
	localparam logic [7:0] VEC_ADDRESS = 8'h03;
	localparam logic [7:0] VEC_PRIV = 8'h08;
	localparam logic [7:0] VEC_TRACE = 8'h09;
	localparam logic [7:0] VEC_AUTO = 8'h18;
	localparam logic [7:0] VEC_TRAP = 8'h20;
	localparam logic [31:0] STACK_STEP = 32'h0000_0004;
	localparam logic [3:0] SP_INDEX = 4'hf;
	typedef enum logic [6:0] {
		ST_NORMAL = 7'h01, ST_VEC = 7'h02, ST_STACK = 7'h04, ST_REFILL = 7'h08,
		ST_STOP = 7'h10, ST_HALT = 7'h20, ST_DBG = 7'h40
	} fsm_t;
	typedef enum logic [3:0] {
		PS_NORMAL = 4'h1, PS_EXCEPTION = 4'h2, PS_STOPPED = 4'h4, PS_HALTED = 4'h8
	} proc_state_t;
	typedef enum logic [3:0] {
		EA_DREG = 4'h0, EA_AREG = 4'h1, EA_IND = 4'h2, EA_POSTINC = 4'h3, EA_PREDEC = 4'h4,
		EA_DISP16 = 4'h5, EA_IDX8 = 4'h6, EA_PC_DISP16 = 4'h7, EA_PC_IDX8 = 4'h8,
		EA_ABS_W = 4'h9, EA_ABS_L = 4'ha, EA_IMM = 4'hb
	} ea_mode_t;
	typedef enum logic [1:0] {SZ_BIT = 2'h0, SZ_BYTE = 2'h1, SZ_WORD = 2'h2, SZ_LONG = 2'h3} op_size_t;
	typedef struct packed {
		logic valid;
		ea_mode_t mode;
		logic [3:0] reg_sel;
		logic [3:0] index_sel;
		logic index_long;
		logic [1:0] scale;
		op_size_t size;
		logic [31:0] ext;
		logic [31:0] pc;
	} ea_req_t;
	typedef struct packed {
		logic trace;
		logic trap;
		logic [3:0] trap_num;
		logic priv_instr;
		logic stop_instr;
		logic sr_write;
		logic ccr_write;
		logic return_from_exception;
		logic [15:0] new_sr;
		logic [31:0] new_pc;
	} core_event_t;
endpackage

// File: hw/core_state_ctrl.sv
/*
 core state sequencer, privilege control, visible register model, effective address unit and AXI4-Lite slave.
 assumes event strobes from the execute pipeline are one-cycle pulses and bus acks arrive while a request is high.
*/
`timescale 1ns/1ps
module core_state_ctrl
	import core_ctrl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register bus
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// execute pipeline
	input wire core_event_t exec_ev,
	input wire logic handler_issued,
	input wire ea_req_t ea_req,
	input wire logic [31:0] fetch_addr,
	// interrupt and bus side
	input wire logic [2:0] irq_level,
	input wire logic bus_access_error,
	input wire logic bus_address_error,
	input wire logic vector_done,
	input wire logic [31:0] vector_data,
	input wire logic stack_done,
	// debug
	input wire logic dbg_halt_req,
	input wire logic dbg_go,
	// state and control outputs
	output proc_state_t proc_state,
	output logic debug_halted,
	output logic bus_quiet,
	output logic supervisor_space,
	output logic fetch_flush,
	output logic [31:0] refill_pc,
	output logic irq_ack,
	output logic vector_req,
	output logic [31:0] vector_addr,
	output logic stack_req,
	output logic [31:0] stack_addr,
	output logic [31:0] stack_data,
	output logic cache_enable,
	output logic fetch_noncacheable,
	// effective address result
	output logic ea_valid,
	output logic ea_is_value,
	output logic ea_illegal,
	output logic [31:0] ea_addr
);
	fsm_t state_reg, state_next;
	logic [15:0] sr_reg, sr_next, saved_sr_reg, saved_sr_next;
	logic [7:0] vec_reg, vec_next;
	logic [31:0] vbase_reg, cache_reg, nc0_reg, nc1_reg;
	logic [31:0] greg [16];
	logic take_exc, exc_irq, flush_next, vreq_next, sreq_next, sp_push;
	logic [7:0] exc_vec;
	logic [31:0] pc_next;
	proc_state_t ps_next;
	logic aw_got_reg, w_got_reg;
	logic [AXI_AW-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;

	// privilege and interrupt qualification
	wire user_mode = !sr_reg[SR_S_BIT];
	wire [2:0] irq_mask = sr_reg[SR_MASK_LSB+2:SR_MASK_LSB];
	wire irq_take = (irq_level == IRQ_NMI_LEVEL) || (irq_level > irq_mask);
	wire bus_err = bus_access_error || bus_address_error;
	wire priv_fault = user_mode && (exec_ev.priv_instr || exec_ev.stop_instr || exec_ev.sr_write);

	// register bus decode
	wire do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
	wire w_greg = aw_addr_reg[7:6] == GREG_PAGE;
	wire [3:0] w_gidx = aw_addr_reg[5:2];
	wire w_sr = do_write && aw_addr_reg == OFF_STATUS;
	wire w_vb = do_write && aw_addr_reg == OFF_VBASE;
	wire w_ca = do_write && aw_addr_reg == OFF_CACHE;
	wire w_n0 = do_write && aw_addr_reg == OFF_NC0;
	wire w_n1 = do_write && aw_addr_reg == OFF_NC1;
	wire w_ok = w_greg || aw_addr_reg == OFF_STATUS || aw_addr_reg == OFF_VBASE || aw_addr_reg == OFF_CACHE
		|| aw_addr_reg == OFF_NC0 || aw_addr_reg == OFF_NC1 || aw_addr_reg == OFF_STATE;
	wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	wire [31:0] sr_word = {16'h0000, sr_reg};
	wire [31:0] sr_merge = (sr_word & ~wmask) | (w_data_reg & wmask);
	wire [31:0] vb_merge = ((vbase_reg & ~wmask) | (w_data_reg & wmask)) & VBASE_KEEP;
	wire [31:0] ca_merge = (cache_reg & ~wmask) | (w_data_reg & wmask);
	wire [31:0] n0_merge = (nc0_reg & ~wmask) | (w_data_reg & wmask);
	wire [31:0] n1_merge = (nc1_reg & ~wmask) | (w_data_reg & wmask);
	wire [31:0] g_merge = (greg[w_gidx] & ~wmask) | (w_data_reg & wmask);
	wire r_greg = s_axi_araddr[7:6] == GREG_PAGE;
	wire [31:0] state_word = {26'h000_0000, debug_halted, bus_quiet, proc_state};
	wire r_ok = r_greg || s_axi_araddr == OFF_STATUS || s_axi_araddr == OFF_VBASE || s_axi_araddr == OFF_CACHE
		|| s_axi_araddr == OFF_NC0 || s_axi_araddr == OFF_NC1 || s_axi_araddr == OFF_STATE;
	wire [31:0] rd_mux = r_greg ? greg[s_axi_araddr[5:2]] :
		s_axi_araddr == OFF_STATUS ? sr_word :
		s_axi_araddr == OFF_VBASE ? vbase_reg :
		s_axi_araddr == OFF_CACHE ? cache_reg :
		s_axi_araddr == OFF_NC0 ? nc0_reg :
		s_axi_araddr == OFF_NC1 ? nc1_reg :
		s_axi_araddr == OFF_STATE ? state_word : WORD_RESET;

	// effective address unit
	wire [31:0] ea_base = greg[ea_req.reg_sel];
	wire [31:0] idx_raw = greg[ea_req.index_sel];
	wire [31:0] idx_val = ea_req.index_long ? idx_raw : {{16{idx_raw[15]}}, idx_raw[15:0]};
	wire [31:0] idx_scaled = idx_val << ea_req.scale;
	wire [31:0] d16 = {{16{ea_req.ext[15]}}, ea_req.ext[15:0]};
	wire [31:0] d8 = {{24{ea_req.ext[7]}}, ea_req.ext[7:0]};
	wire [31:0] ea_step = ea_req.size == SZ_LONG ? 32'h0000_0004 :
		ea_req.size == SZ_WORD ? 32'h0000_0002 : 32'h0000_0001;
	wire ea_base_mode = ea_req.mode == EA_IND || ea_req.mode == EA_POSTINC || ea_req.mode == EA_PREDEC
		|| ea_req.mode == EA_DISP16 || ea_req.mode == EA_IDX8;
	wire ea_bad = ea_base_mode && !ea_req.reg_sel[3];
	wire ea_value_mode = ea_req.mode == EA_DREG || ea_req.mode == EA_AREG || ea_req.mode == EA_IMM;
	wire [31:0] ea_calc =
		ea_req.mode == EA_DREG || ea_req.mode == EA_AREG ? ea_base :
		ea_req.mode == EA_IND || ea_req.mode == EA_POSTINC ? ea_base :
		ea_req.mode == EA_PREDEC ? ea_base - ea_step :
		ea_req.mode == EA_DISP16 ? ea_base + d16 :
		ea_req.mode == EA_IDX8 ? ea_base + d8 + idx_scaled :
		ea_req.mode == EA_PC_DISP16 ? ea_req.pc + d16 :
		ea_req.mode == EA_PC_IDX8 ? ea_req.pc + d8 + idx_scaled :
		ea_req.mode == EA_ABS_W ? d16 : ea_req.ext;
	wire ea_upd = ea_req.valid && !ea_bad && (ea_req.mode == EA_POSTINC || ea_req.mode == EA_PREDEC);
	wire [31:0] ea_wb = ea_req.mode == EA_POSTINC ? ea_base + ea_step : ea_base - ea_step;

	// noncacheable region match
	wire nc0_hit = nc0_reg[NC_EN_BIT] && ((fetch_addr[31:24] ^ nc0_reg[31:24]) & ~nc0_reg[23:16]) == 8'h00;
	wire nc1_hit = nc1_reg[NC_EN_BIT] && ((fetch_addr[31:24] ^ nc1_reg[31:24]) & ~nc1_reg[23:16]) == 8'h00;

	// sequencer
	always_comb
	begin
		state_next = state_reg;
		sr_next = w_sr ? sr_merge[15:0] : sr_reg;
		saved_sr_next = saved_sr_reg;
		vec_next = vec_reg;
		take_exc = 1'b0;
		exc_irq = 1'b0;
		exc_vec = 8'h00;
		flush_next = 1'b0;
		pc_next = refill_pc;
		vreq_next = vector_req;
		sreq_next = stack_req;
		sp_push = 1'b0;
		case (state_reg)
			ST_NORMAL:
			begin
				if (dbg_halt_req)
					state_next = ST_DBG;
				else if (bus_err)
				begin
					take_exc = 1'b1;
					exc_vec = bus_access_error ? VEC_ACCESS : VEC_ADDRESS;
				end
				else if (irq_take)
				begin
					take_exc = 1'b1;
					exc_irq = 1'b1;
					exc_vec = VEC_AUTO + {5'h00, irq_level};
				end
				else if (priv_fault)
				begin
					take_exc = 1'b1;
					exc_vec = VEC_PRIV;
				end
				else if (exec_ev.trap)
				begin
					take_exc = 1'b1;
					exc_vec = VEC_TRAP + {4'h0, exec_ev.trap_num};
				end
				else if (exec_ev.trace)
				begin
					take_exc = 1'b1;
					exc_vec = VEC_TRACE;
				end
				else
				begin
					if (exec_ev.stop_instr)
					begin
						sr_next = exec_ev.new_sr;
						state_next = ST_STOP;
					end
					if (exec_ev.sr_write || exec_ev.return_from_exception)
					begin
						sr_next = exec_ev.new_sr;
						flush_next = 1'b1;
						pc_next = exec_ev.new_pc;
					end
					else if (exec_ev.ccr_write)
						sr_next = {sr_reg[15:8], exec_ev.new_sr[7:0]};
				end
			end
			ST_STOP:
			begin
				if (dbg_halt_req)
					state_next = ST_DBG;
				else if (irq_take)
				begin
					take_exc = 1'b1;
					exc_irq = 1'b1;
					exc_vec = VEC_AUTO + {5'h00, irq_level};
				end
			end
			ST_VEC:
			begin
				if (bus_err)
				begin
					state_next = ST_HALT;
					vreq_next = 1'b0;
				end
				else if (vector_done)
				begin
					vreq_next = 1'b0;
					sreq_next = 1'b1;
					pc_next = vector_data;
					state_next = ST_STACK;
				end
			end
			ST_STACK:
			begin
				if (bus_err)
				begin
					state_next = ST_HALT;
					sreq_next = 1'b0;
				end
				else if (stack_done)
				begin
					sreq_next = 1'b0;
					sp_push = 1'b1;
					flush_next = 1'b1;
					state_next = ST_REFILL;
				end
			end
			ST_REFILL:
			begin
				if (bus_err)
					state_next = ST_HALT;
				else if (handler_issued)
					state_next = ST_NORMAL;
			end
			ST_HALT:
				state_next = ST_HALT;
			ST_DBG:
			begin
				if (dbg_go)
					state_next = ST_NORMAL;
			end
			default:
				state_next = ST_HALT;
		endcase
		if (take_exc)
		begin
			saved_sr_next = sr_reg;
			sr_next = sr_reg;
			sr_next[SR_S_BIT] = 1'b1;
			sr_next[SR_T_BIT] = 1'b0;
			if (exc_irq)
				sr_next[SR_MASK_LSB+2:SR_MASK_LSB] = irq_level;
			vec_next = exc_vec;
			vreq_next = 1'b1;
			state_next = ST_VEC;
		end
	end

	// reported state
	always_comb
	begin
		case (state_next)
			ST_NORMAL: ps_next = PS_NORMAL;
			ST_VEC, ST_STACK, ST_REFILL: ps_next = PS_EXCEPTION;
			ST_STOP: ps_next = PS_STOPPED;
			default: ps_next = PS_HALTED;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_NORMAL;
			proc_state <= PS_NORMAL;
			sr_reg <= SR_RESET;
			saved_sr_reg <= SR_RESET;
			vec_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			proc_state <= ps_next;
			sr_reg <= sr_next;
			saved_sr_reg <= saved_sr_next;
			vec_reg <= vec_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			debug_halted <= 1'b0;
			bus_quiet <= 1'b0;
			supervisor_space <= SR_RESET[SR_S_BIT];
			fetch_flush <= 1'b0;
			refill_pc <= WORD_RESET;
			irq_ack <= 1'b0;
			vector_req <= 1'b0;
			stack_req <= 1'b0;
		end
		else
		begin
			debug_halted <= state_next == ST_DBG;
			bus_quiet <= state_next == ST_STOP || state_next == ST_HALT || state_next == ST_DBG;
			supervisor_space <= sr_next[SR_S_BIT];
			fetch_flush <= flush_next;
			refill_pc <= pc_next;
			irq_ack <= exc_irq;
			vector_req <= vreq_next;
			stack_req <= sreq_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			vector_addr <= WORD_RESET;
			stack_addr <= WORD_RESET;
			stack_data <= WORD_RESET;
		end
		else
		begin
			if (take_exc)
				vector_addr <= vbase_reg + {22'h00_0000, exc_vec, 2'h0};
			if (state_reg == ST_VEC && vector_done)
			begin
				stack_addr <= greg[SP_INDEX] - STACK_STEP;
				stack_data <= {8'h00, vec_reg, saved_sr_reg};
			end
		end
	end

	// control registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			vbase_reg <= WORD_RESET;
			cache_reg <= WORD_RESET;
			nc0_reg <= WORD_RESET;
			nc1_reg <= WORD_RESET;
			cache_enable <= 1'b0;
			fetch_noncacheable <= 1'b0;
		end
		else
		begin
			if (w_vb)
				vbase_reg <= vb_merge;
			if (w_ca)
				cache_reg <= ca_merge;
			if (w_n0)
				nc0_reg <= n0_merge;
			if (w_n1)
				nc1_reg <= n1_merge;
			cache_enable <= cache_reg[CACHE_EN_BIT];
			fetch_noncacheable <= nc0_hit || nc1_hit;
		end
	end

	// general registers, stack push over address update over bus write
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_greg
			wire sel_sp = sp_push && gi == SP_INDEX;
			wire sel_ea = ea_upd && ea_req.reg_sel == gi;
			wire sel_bus = do_write && w_greg && w_gidx == gi;
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
					greg[gi] <= WORD_RESET;
				else if (sel_sp)
					greg[gi] <= greg[gi] - STACK_STEP;
				else if (sel_ea)
					greg[gi] <= ea_wb;
				else if (sel_bus)
					greg[gi] <= g_merge;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ea_valid <= 1'b0;
			ea_is_value <= 1'b0;
			ea_illegal <= 1'b0;
			ea_addr <= WORD_RESET;
		end
		else
		begin
			ea_valid <= ea_req.valid;
			ea_is_value <= ea_req.valid && ea_value_mode;
			ea_illegal <= ea_req.valid && ea_bad;
			if (ea_req.valid)
				ea_addr <= ea_calc;
		end
	end

	// register bus write side
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= WORD_RESET;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[AXI_AW-1:2], 2'h0};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// register bus read side
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= WORD_RESET;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= r_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// File: verif/bus_partner.sv
/*
 far-side model: answers vector fetches and stack pushes, or faults them.
 assumes requests hold until answered.
*/
`timescale 1ns/1ps
module bus_partner
	import core_ctrl_pkg::*;
#(
	parameter logic [31:0] HANDLER = 32'h0000_2000
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// bench controls
	input wire logic slow,
	input wire logic [1:0] fault,
	// core side
	input wire logic vector_req,
	input wire logic stack_req,
	output logic vector_done,
	output logic [31:0] vector_data,
	output logic stack_done,
	output logic bus_access_error,
	output logic bus_address_error
);
	logic [2:0] wait_reg;
	logic busy, fin;
	assign busy = (vector_req || stack_req) && !vector_done && !stack_done && !bus_access_error && !bus_address_error;
	assign fin = busy && wait_reg == (slow ? 3'h4 : 3'h1);
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
		begin
			wait_reg <= 3'h0;
			vector_done <= 1'b0;
			stack_done <= 1'b0;
			bus_access_error <= 1'b0;
			bus_address_error <= 1'b0;
			vector_data <= 32'h0000_0000;
		end
		else
		begin
			wait_reg <= busy && !fin ? wait_reg + 3'h1 : 3'h0;
			vector_done <= fin && vector_req && fault != 2'h1;
			bus_access_error <= fin && vector_req && fault == 2'h1;
			stack_done <= fin && stack_req && fault != 2'h2;
			bus_address_error <= fin && stack_req && fault == 2'h2;
			vector_data <= fin ? HANDLER : ~vector_data;
		end
endmodule

// File: verif/core_state_ctrl_sva.sv
/*
 checker for core_state_ctrl.
 bound to the design top; sees only its ports.
*/
`timescale 1ns/1ps
module core_state_ctrl_sva
	import core_ctrl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// causes
	input wire core_event_t exec_ev,
	input wire logic handler_issued,
	input wire logic [2:0] irq_level,
	input wire logic bus_access_error,
	input wire logic bus_address_error,
	input wire logic vector_done,
	input wire logic stack_done,
	input wire logic dbg_halt_req,
	// effects
	input wire proc_state_t proc_state,
	input wire logic debug_halted,
	input wire logic bus_quiet,
	input wire logic supervisor_space,
	input wire logic fetch_flush,
	input wire logic [31:0] refill_pc,
	input wire logic irq_ack,
	input wire logic vector_req,
	input wire logic [31:0] vector_addr,
	input wire logic stack_req
);
	logic err, calm, idle;
	assign err = bus_access_error || bus_address_error;
	assign calm = !err && !dbg_halt_req && irq_level == 3'h0;
	assign idle = !vector_req && !stack_req;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_vec_got;
		vector_req && vector_done && !err && !dbg_halt_req;
	endsequence
	sequence s_stack_got;
		stack_req && stack_done && !err && !dbg_halt_req;
	endsequence
	a_one_state: assert property ($onehot(proc_state)) else $error("state not one-hot");
	a_trap_entry: assert property (proc_state == PS_NORMAL && exec_ev.trap && calm
		|=> proc_state == PS_EXCEPTION && vector_req && supervisor_space) else $error("trap not taken");
	a_vec_stack: assert property (s_vec_got |=> !vector_req && stack_req) else $error("no stack after vector");
	a_stack_flush: assert property (s_stack_got |=> fetch_flush && idle) else $error("no refill after stack");
	a_exc_end: assert property (proc_state == PS_EXCEPTION && handler_issued && idle && !fetch_flush && calm
		|=> proc_state == PS_NORMAL) else $error("exception did not end");
	a_nest_halt: assert property (proc_state == PS_EXCEPTION && err && !dbg_halt_req
		|=> proc_state == PS_HALTED && idle && !fetch_flush) else $error("nested error did not halt");
	a_halt_stays: assert property (proc_state == PS_HALTED && !debug_halted
		|=> (proc_state == PS_HALTED) [*3]) else $error("halt released");
	a_stop_quiet: assert property (proc_state == PS_STOPPED |-> bus_quiet && idle) else $error("stop not quiet");
	a_wake_irq: assert property (proc_state == PS_STOPPED && irq_level == IRQ_NMI_LEVEL && !err && !dbg_halt_req
		|=> proc_state == PS_EXCEPTION && irq_ack && vector_addr[9:0] == {VEC_AUTO + 8'h07, 2'b00})
		else $error("wake not taken");
	a_user_priv: assert property (proc_state == PS_NORMAL && !supervisor_space && exec_ev.stop_instr && calm
		|=> proc_state == PS_EXCEPTION && supervisor_space && vector_addr[9:0] == {VEC_PRIV, 2'b00})
		else $error("user stop not refused");
	a_sr_flush: assert property (proc_state == PS_NORMAL && supervisor_space && exec_ev.sr_write
		&& !exec_ev.trap && !exec_ev.trace && calm |=> fetch_flush && refill_pc == $past(exec_ev.new_pc)
		&& supervisor_space == $past(exec_ev.new_sr[SR_S_BIT])) else $error("status write no flush");
	a_dbg_halt: assert property (proc_state == PS_NORMAL && dbg_halt_req
		|=> proc_state == PS_HALTED && debug_halted) else $error("debug halt missed");
endmodule

bind core_state_ctrl core_state_ctrl_sva i_core_state_ctrl_sva (.*);

// File: verif/processor_state_privilege_control_tb.sv
/*
 bench for core_state_ctrl.
 assumes the bus partner and bound checker.
*/
`timescale 1ns/1ps
module processor_state_privilege_control_tb;
	import core_ctrl_pkg::*;
	logic ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, handler_issued, bus_access_error;
	logic bus_address_error, vector_done, stack_done, dbg_halt_req, dbg_go, debug_halted, bus_quiet;
	logic supervisor_space, fetch_flush, irq_ack, vector_req, stack_req, cache_enable, fetch_noncacheable;
	logic ea_valid, ea_is_value, ea_illegal, slow, halted;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, fetch_addr, vector_data, refill_pc, vector_addr, stack_addr, stack_data;
	logic [31:0] ea_addr;
	logic [1:0] s_axi_bresp, s_axi_rresp, fault;
	logic [2:0] irq_level;
	logic [3:0] s_axi_wstrb;
	core_event_t exec_ev;
	ea_req_t ea_req;
	proc_state_t proc_state;
	int n_errors, checked;
	assign halted = proc_state === PS_HALTED;
	core_state_ctrl i_core_state_ctrl (.*);
	bus_partner i_bus_partner (.*);
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic hang;
		n_errors++;
		tally_and_finish();
	endtask
	task automatic wait_hi(ref logic s);
		int k;
		for (k = 0; k < 60 && s !== 1'b1; k++)
		begin
			@(posedge ref_clk);
			#1;
		end
		if (k == 60)
			hang();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 60 && !s_axi_bvalid; k++)
		begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (k == 60)
			hang();
		cmp("bresp", 32'(r), 32'(s_axi_bresp));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 60 && !s_axi_rvalid; k++)
		begin
			@(posedge ref_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (k == 60)
			hang();
		cmp("rdata", d, s_axi_rdata);
		cmp("rresp", 32'(r), 32'(s_axi_rresp));
	endtask
	task automatic fire(input core_event_t e);
		@(posedge ref_clk);
		exec_ev <= e;
		@(posedge ref_clk);
		exec_ev <= '0;
		#1;
	endtask
	task automatic run_exc(input logic [31:0] va, input logic [31:0] sd, input logic [31:0] sa, input logic ack);
		wait_hi(vector_req);
		cmp("state", 32'(PS_EXCEPTION), 32'(proc_state));
		cmp("vaddr", va, vector_addr);
		cmp("super", 32'h1, 32'(supervisor_space));
		cmp("ack", 32'(ack), 32'(irq_ack));
		@(posedge ref_clk);
		irq_level <= 3'h0;
		wait_hi(stack_req);
		cmp("sdata", sd, stack_data);
		cmp("saddr", sa, stack_addr);
		wait_hi(fetch_flush);
		cmp("refill", 32'h0000_2000, refill_pc);
		cmp("state", 32'(PS_EXCEPTION), 32'(proc_state));
		@(posedge ref_clk);
		handler_issued <= 1'b1;
		@(posedge ref_clk);
		handler_issued <= 1'b0;
		#1;
		cmp("state", 32'(PS_NORMAL), 32'(proc_state));
	endtask
	task automatic ea_go(input ea_req_t r, input logic [31:0] a, input logic ill);
		@(posedge ref_clk);
		ea_req <= r;
		@(posedge ref_clk);
		ea_req <= '0;
		#1;
		cmp("ea_valid", 32'h1, 32'(ea_valid));
		cmp("ea_illegal", 32'(ill), 32'(ea_illegal));
		cmp("ea_val", 32'h0, 32'(ea_is_value));
		if (!ill)
			cmp("ea_addr", a, ea_addr);
	endtask
	task automatic t_regs;
		rd(OFF_STATUS, 32'h0000_2700, RESP_OKAY);
		wr(OFF_STATE, 32'h0000_0008, RESP_OKAY);
		rd(OFF_STATE, 32'h0000_0001, RESP_OKAY);
		wr(OFF_VBASE, 32'hffff_ffff, RESP_OKAY);
		rd(OFF_VBASE, 32'hfff0_0000, RESP_OKAY);
		wr(OFF_VBASE, 32'h0010_0000, RESP_OKAY);
		wr(8'h30, 32'h1234_5678, RESP_SLVERR);
		rd(8'h30, 32'h0000_0000, RESP_SLVERR);
		wr(OFF_CACHE, 32'h8000_0000, RESP_OKAY);
		wr(OFF_NC1, 32'h4000_8000, RESP_OKAY);
		@(posedge ref_clk);
		fetch_addr <= 32'h4000_0100;
		repeat (2) @(posedge ref_clk);
		#1;
		cmp("cache", 32'h1, 32'(cache_enable));
		cmp("noncache", 32'h1, 32'(fetch_noncacheable));
	endtask
	task automatic t_exc;
		slow <= 1'b1;
		fire('{trap: 1'b1, trap_num: 4'h3, default: '0});
		run_exc(32'h0010_008c, 32'h0023_2700, 32'hffff_fffc, 1'b0);
		slow <= 1'b0;
		fire('{sr_write: 1'b1, new_sr: 16'h0000, new_pc: 32'h0000_3000, default: '0});
		cmp("flush", 32'h1, 32'(fetch_flush));
		cmp("refill", 32'h0000_3000, refill_pc);
		cmp("super", 32'h0, 32'(supervisor_space));
		fire('{ccr_write: 1'b1, new_sr: 16'h271f, default: '0});
		rd(OFF_STATUS, 32'h0000_001f, RESP_OKAY);
		fire('{stop_instr: 1'b1, new_sr: 16'h2700, default: '0});
		run_exc(32'h0010_0020, 32'h0008_001f, 32'hffff_fff8, 1'b0);
		fire('{stop_instr: 1'b1, new_sr: 16'h2700, default: '0});
		cmp("state", 32'(PS_STOPPED), 32'(proc_state));
		cmp("quiet", 32'h1, 32'(bus_quiet));
		@(posedge ref_clk);
		irq_level <= 3'h5;
		repeat (4) @(posedge ref_clk);
		#1;
		cmp("state", 32'(PS_STOPPED), 32'(proc_state));
		@(posedge ref_clk);
		irq_level <= 3'h7;
		run_exc(32'h0010_007c, 32'h001f_2700, 32'hffff_fff4, 1'b1);
	endtask
	task automatic t_ea;
		wr(8'h40, 32'h0000_0003, RESP_OKAY);
		wr(8'h60, 32'h0000_1000, RESP_OKAY);
		rd(8'h7c, 32'hffff_fff4, RESP_OKAY);
		ea_go('{valid: 1'b1, mode: EA_IDX8, reg_sel: 4'h8, index_long: 1'b1, scale: 2'h2, size: SZ_LONG,
			ext: 32'hffff_fff0, default: '0}, 32'h0000_0ffc, 1'b0);
		ea_go('{valid: 1'b1, mode: EA_PREDEC, reg_sel: 4'h8, size: SZ_LONG, default: '0}, 32'h0000_0ffc, 1'b0);
		rd(8'h60, 32'h0000_0ffc, RESP_OKAY);
		ea_go('{valid: 1'b1, mode: EA_IND, size: SZ_WORD, default: '0}, 32'h0000_0000, 1'b1);
	endtask
	task automatic t_halt;
		@(posedge ref_clk);
		dbg_halt_req <= 1'b1;
		@(posedge ref_clk);
		dbg_halt_req <= 1'b0;
		#1;
		cmp("debug", 32'h1, 32'(debug_halted));
		@(posedge ref_clk);
		dbg_go <= 1'b1;
		@(posedge ref_clk);
		dbg_go <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		cmp("state", 32'(PS_NORMAL), 32'(proc_state));
		for (int f = 1; f < 3; f++)
		begin
			fault <= 2'(f);
			fire('{trap: 1'b1, default: '0});
			wait_hi(halted);
			cmp("reqs", 32'h0, {30'h0, vector_req, stack_req});
			@(posedge ref_clk);
			irq_level <= 3'h7;
			fault <= 2'h0;
			fire('{trap: 1'b1, default: '0});
			repeat (4) @(posedge ref_clk);
			#1;
			cmp("state", 32'(PS_HALTED), 32'(proc_state));
			@(posedge ref_clk);
			irq_level <= 3'h0;
			rst <= 1'b1;
			@(posedge ref_clk);
			rst <= 1'b0;
			#1;
			cmp("state", 32'(PS_NORMAL), 32'(proc_state));
		end
	endtask
	initial
	begin
		n_errors = 0;
		checked = 0;
		rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fetch_addr} = '0;
		{handler_issued, dbg_halt_req, dbg_go, slow, fault, irq_level} = '0;
		exec_ev = '0;
		ea_req = '0;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		cmp("super", 32'h1, 32'(supervisor_space));
		t_regs();
		t_exc();
		t_ea();
		t_halt();
		tally_and_finish();
	end
endmodule
